// ---- nmlib_pkg.sv ----
// nmlib_pkg: constants and carriers for the multi-lun nand host sequencer
// assumes one async nand target, x8 bus, two luns behind one chip enable
package nmlib_pkg;
    localparam logic [7:0] CMD_RESET = 8'hff;
    localparam logic [7:0] CMD_READ1 = 8'h00;
    localparam logic [7:0] CMD_READ2 = 8'h30;
    localparam logic [7:0] CMD_PROG1 = 8'h80;
    localparam logic [7:0] CMD_PROG2 = 8'h10;
    localparam logic [7:0] CMD_ERASE1 = 8'h60;
    localparam logic [7:0] CMD_ERASE2 = 8'hd0;
    localparam logic [7:0] CMD_STAT_ENH = 8'h78;
    localparam logic [7:0] CMD_STAT_PLAIN = 8'h70;
    localparam int CLK_PERIOD_NS = 20;
    localparam int T_STROBE_NS = 25;
    localparam int STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int T_WB_NS = 100;
    localparam int WB_CYC = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] ADDR_CYC_FULL = 3'h5;
    localparam logic [2:0] ADDR_CYC_ROW = 3'h3;
    localparam logic [12:0] SPARE_COL = 13'h1000;
    localparam logic [7:0] BB_MARK = 8'h00;
    localparam logic [9:0] ECC_SECTOR_BYTES = 10'h21c;
    localparam int ST_FAIL = 0;
    localparam int ST_ARRAY_RDY = 5;
    localparam int ST_CACHE_RDY = 6;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_RDATA = 8'h0c;
    localparam logic [7:0] REG_STAT = 8'h10;
    localparam logic [7:0] REG_LEN = 8'h14;
    localparam int ADDR_PAGE_LSB = 13;
    localparam int ADDR_BLK_LSB = 19;
    localparam int ADDR_LUN_BIT = 31;
    localparam int CTRL_NOWAIT_BIT = 3;
    typedef enum logic [2:0] {
        OP_RESET, OP_READ, OP_PROG, OP_ERASE, OP_BBCHK, OP_POLL
    } nmlib_op_type;
    typedef struct packed {
        logic ce_n;
        logic cle;
        logic ale;
        logic we_n;
        logic re_n;
        logic wp_n;
        logic [7:0] io_out;
        logic io_oe;
    } nmlib_pins_type;
    typedef struct packed {
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
    } nmlib_ahb_rsp_type;
endpackage : nmlib_pkg

// ---- nmlib_host.sv ----
// nmlib_host: nand host sequencer with an ahb-lite register slave
// assumes nand pins sampled on clk, rb_n already pulled up outside
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
module nmlib_host
    import nmlib_pkg::*;
#(
    parameter int BLOCKS_PER_LUN = 4096,
    parameter int LEN_W = 13
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // nand pins
    output nmlib_pins_type pins,
    input wire logic [7:0] io_in,
    input wire logic rb_n,
    // ecc engine hook
    output logic ecc_sector_end
);
    localparam int NUM_LUN = 2;
    localparam int BBT_N = NUM_LUN * BLOCKS_PER_LUN;
    typedef enum logic [3:0] {
        S_IDLE, S_CMD1, S_ADDR, S_DIN, S_CMD2, S_WAIT, S_RBWAIT,
        S_PCMD, S_PADDR, S_PRD, S_RCMD, S_DOUT, S_DONE
    } nmlib_st_type;
    typedef struct packed {
        nmlib_st_type st;
        nmlib_op_type op;
        logic nowait;
        logic lun;
        logic [11:0] blk;
        logic [7:0] cmd1;
        logic [7:0] cmd2;
        logic [39:0] addr_sh;
        logic [23:0] poll_sh;
        logic [2:0] naddr;
        logic [7:0] cnt;
        logic ph;
        logic stall;
        logic [LEN_W-1:0] len;
        logic [LEN_W-1:0] dcnt;
        logic [9:0] sect;
        logic ecc_end;
        logic [NUM_LUN-1:0] lun_busy;
        logic init_done;
        logic refused;
        logic fail;
        logic bad_found;
        logic [7:0] rdata;
        logic [7:0] wdata;
        logic [7:0] stat;
        logic rvalid;
        logic wfull;
        logic [31:0] addr_reg;
        logic [LEN_W-1:0] len_reg;
        logic wr_pend;
        logic [7:0] wr_addr;
        nmlib_pins_type pins;
        nmlib_ahb_rsp_type ahb;
    } nmlib_state_type;

    nmlib_state_type r_reg, r_next;
    logic bbt_reg [BBT_N];
    logic bbt_we;
    logic start_req, start_ok, edge_done, sample, bad_sel, wr_st, rd_st;
    logic [23:0] row;
    nmlib_op_type req_op;

    assign row = {5'h0, r_reg.addr_reg[ADDR_LUN_BIT],
        r_reg.addr_reg[ADDR_LUN_BIT-1:ADDR_PAGE_LSB]};
    assign req_op = nmlib_op_type'(hwdata[2:0]);
    assign bad_sel = bbt_reg[{r_reg.addr_reg[ADDR_LUN_BIT],
        r_reg.addr_reg[ADDR_LUN_BIT-1:ADDR_BLK_LSB]}];

    always_comb begin
        r_next = r_reg;
        bbt_we = 1'b0;
        start_req = r_reg.wr_pend && r_reg.wr_addr == REG_CTRL;
        start_ok = 1'b0;
        // a stalled strobe must not count its high half again
        edge_done = r_reg.ph && r_reg.cnt == 8'(STROBE_CYC - 1)
            && !r_reg.stall;
        sample = !r_reg.ph && r_reg.cnt == 8'(STROBE_CYC - 1)
            && !r_reg.stall;
        r_next.ecc_end = 1'b0;
        r_next.ahb.hreadyout = 1'b1;
        r_next.ahb.hresp = 1'b0;
        // ahb address phase: reads answered from here in the data phase
        r_next.wr_pend = 1'b0;
        if (hsel && htrans[1] && hready) begin
            r_next.wr_pend = hwrite;
            r_next.wr_addr = haddr[7:0];
            r_next.ahb.hrdata = 32'h0;
            if (!hwrite) begin
                case (haddr[7:0])
                    REG_ADDR: r_next.ahb.hrdata = r_reg.addr_reg;
                    REG_LEN: r_next.ahb.hrdata = 32'(r_reg.len_reg);
                    REG_RDATA: begin
                        r_next.ahb.hrdata = {24'h0, r_reg.rdata};
                        r_next.rvalid = 1'b0;
                    end
                    REG_STAT: r_next.ahb.hrdata = {14'h0,
                        r_reg.stat[ST_CACHE_RDY], r_reg.bad_found,
                        r_reg.stat, r_reg.lun_busy, r_reg.wfull,
                        r_reg.rvalid, r_reg.fail, r_reg.refused,
                        r_reg.init_done, r_reg.st != S_IDLE};
                    default: r_next.ahb.hrdata = 32'h0;
                endcase
            end
        end
        // ahb data phase writes
        if (r_reg.wr_pend) begin
            case (r_reg.wr_addr)
                REG_ADDR: r_next.addr_reg = hwdata;
                REG_LEN: r_next.len_reg = hwdata[LEN_W-1:0];
                REG_WDATA: begin
                    r_next.wdata = hwdata[7:0];
                    r_next.wfull = 1'b1;
                end
                REG_CTRL: r_next.refused = 1'b0;
                default: r_next.wdata = r_reg.wdata;
            endcase
        end
        // pin cycle timer: low half then high half of a strobe
        if (r_reg.st != S_IDLE && !r_reg.stall) begin
            if (r_reg.cnt == 8'(STROBE_CYC - 1)) begin
                r_next.cnt = 8'h0;
                r_next.ph = !r_reg.ph;
            end else begin
                r_next.cnt = r_reg.cnt + 8'h1;
            end
        end
        case (r_reg.st)
            S_IDLE: begin
                r_next.cnt = 8'h0;
                r_next.ph = 1'b0;
                if (start_req) begin
                    if ((req_op != OP_RESET && !r_reg.init_done)
                        || (req_op != OP_POLL && req_op != OP_RESET
                        && r_reg.lun_busy[row[18]])
                        || ((req_op == OP_PROG || req_op == OP_ERASE)
                        && bad_sel)
                        || (req_op == OP_PROG && r_reg.rvalid)) begin
                        r_next.refused = 1'b1;
                    end else begin
                        start_ok = 1'b1;
                        r_next.op = req_op;
                        r_next.nowait = hwdata[CTRL_NOWAIT_BIT];
                        r_next.lun = row[18];
                        r_next.blk = row[17:6];
                        r_next.poll_sh = row;
                        r_next.addr_sh = {row, 3'h0,
                            r_reg.addr_reg[ADDR_PAGE_LSB-1:0]};
                        r_next.naddr = ADDR_CYC_FULL;
                        r_next.len = r_reg.len_reg;
                        r_next.dcnt = '0;
                        r_next.st = S_CMD1;
                        r_next.fail = 1'b0;
                        r_next.bad_found = 1'b0;
                        case (req_op)
                            OP_RESET: begin
                                r_next.cmd1 = CMD_RESET;
                                r_next.naddr = 3'h0;
                                r_next.init_done = 1'b0;
                            end
                            OP_PROG: begin
                                r_next.cmd1 = CMD_PROG1;
                                r_next.cmd2 = CMD_PROG2;
                            end
                            OP_ERASE: begin
                                r_next.cmd1 = CMD_ERASE1;
                                r_next.cmd2 = CMD_ERASE2;
                                r_next.addr_sh = {16'h0, row};
                                r_next.naddr = ADDR_CYC_ROW;
                            end
                            OP_BBCHK: begin
                                r_next.cmd1 = CMD_READ1;
                                r_next.cmd2 = CMD_READ2;
                                r_next.addr_sh = {row[23:6], 6'h0,
                                    3'h0, SPARE_COL};
                                r_next.len = LEN_W'(1);
                            end
                            OP_POLL: r_next.st = S_PCMD;
                            default: begin
                                r_next.cmd1 = CMD_READ1;
                                r_next.cmd2 = CMD_READ2;
                            end
                        endcase
                    end
                end
            end
            S_CMD1: if (edge_done) begin
                r_next.st = r_reg.naddr != 3'h0 ? S_ADDR : S_WAIT;
            end
            S_ADDR: if (edge_done) begin
                r_next.addr_sh = r_reg.addr_sh >> 8;
                r_next.naddr = r_reg.naddr - 3'h1;
                if (r_reg.naddr == 3'h1) begin
                    r_next.st = r_reg.op == OP_PROG && r_reg.len != '0 ?
                        S_DIN : S_CMD2;
                end
            end
            S_DIN: begin
                r_next.stall = !r_next.wfull;
                if (edge_done) begin
                    r_next.wfull = r_reg.wr_pend
                        && r_reg.wr_addr == REG_WDATA;
                    r_next.dcnt = r_reg.dcnt + LEN_W'(1);
                    r_next.sect = r_reg.sect + 10'h1;
                    if (r_reg.dcnt == r_reg.len - LEN_W'(1)) begin
                        r_next.st = S_CMD2;
                    end
                end
            end
            S_CMD2: if (edge_done) begin
                r_next.st = S_WAIT;
            end
            S_WAIT: begin
                r_next.ph = 1'b1;
                // own count: the strobe timer wraps long before this
                r_next.cnt = r_reg.cnt + 8'h1;
                if (r_reg.cnt == 8'(WB_CYC)) begin
                    r_next.cnt = 8'h0;
                    r_next.ph = 1'b0;
                    r_next.lun_busy[r_reg.lun] = 1'b1;
                    if (r_reg.op == OP_RESET) begin
                        r_next.st = S_RBWAIT;
                    end else if (r_reg.nowait && r_reg.op != OP_READ
                        && r_reg.op != OP_BBCHK) begin
                        r_next.st = S_DONE;
                    end else begin
                        r_next.st = S_PCMD;
                    end
                end
            end
            S_RBWAIT: begin
                r_next.ph = 1'b1;
                if (rb_n) begin
                    r_next.init_done = 1'b1;
                    r_next.lun_busy = '0;
                    r_next.st = S_DONE;
                end
            end
            S_PCMD: if (edge_done) begin
                r_next.st = S_PADDR;
                r_next.naddr = ADDR_CYC_ROW;
            end
            S_PADDR: if (edge_done) begin
                r_next.poll_sh = r_reg.poll_sh >> 8;
                r_next.naddr = r_reg.naddr - 3'h1;
                if (r_reg.naddr == 3'h1) begin
                    r_next.st = S_PRD;
                    r_next.poll_sh = {5'h0, r_reg.lun, r_reg.blk, 6'h0};
                end
            end
            S_PRD: begin
                if (sample) begin
                    r_next.stat = io_in;
                end
                if (edge_done) begin
                    r_next.st = S_PCMD;
                    if (r_reg.stat[ST_ARRAY_RDY]) begin
                        r_next.lun_busy[r_reg.lun] = 1'b0;
                        r_next.fail = r_reg.stat[ST_FAIL];
                        r_next.st = r_reg.op == OP_READ
                            || r_reg.op == OP_BBCHK ? S_RCMD : S_DONE;
                    end
                end
            end
            S_RCMD: if (edge_done) begin
                r_next.st = S_DOUT;
            end
            S_DOUT: begin
                r_next.stall = r_reg.rvalid;
                if (sample) begin
                    r_next.rdata = io_in;
                    r_next.rvalid = r_reg.op == OP_READ;
                    r_next.sect = r_reg.sect + 10'h1;
                    if (r_reg.op == OP_BBCHK && io_in == BB_MARK) begin
                        r_next.bad_found = 1'b1;
                        bbt_we = 1'b1;
                    end
                end
                if (edge_done) begin
                    r_next.dcnt = r_reg.dcnt + LEN_W'(1);
                    if (r_reg.dcnt == r_reg.len - LEN_W'(1)) begin
                        r_next.st = S_DONE;
                    end
                end
            end
            S_DONE: begin
                r_next.st = S_IDLE;
                r_next.sect = 10'h0;
                r_next.stall = 1'b0;
            end
            default: r_next.st = S_IDLE;
        endcase
        if (r_next.sect == ECC_SECTOR_BYTES) begin
            r_next.sect = 10'h0;
            r_next.ecc_end = 1'b1;
        end
        // pins follow the next state so they leave a flop
        wr_st = r_next.st inside {S_CMD1, S_ADDR, S_DIN, S_CMD2,
            S_PCMD, S_PADDR, S_RCMD};
        rd_st = r_next.st inside {S_PRD, S_DOUT};
        r_next.pins.ce_n = r_next.st == S_IDLE;
        r_next.pins.wp_n = 1'b1;
        r_next.pins.cle = r_next.st inside {S_CMD1, S_CMD2, S_PCMD,
            S_RCMD};
        r_next.pins.ale = r_next.st inside {S_ADDR, S_PADDR};
        r_next.pins.we_n = !(wr_st && !r_next.ph && !r_next.stall);
        r_next.pins.re_n = !(rd_st && !r_next.ph && !r_next.stall);
        r_next.pins.io_oe = wr_st;
        case (r_next.st)
            S_CMD1: r_next.pins.io_out = r_next.cmd1;
            S_ADDR: r_next.pins.io_out = r_next.addr_sh[7:0];
            S_DIN: r_next.pins.io_out = r_next.wdata;
            S_CMD2: r_next.pins.io_out = r_next.cmd2;
            S_PCMD: r_next.pins.io_out = CMD_STAT_ENH;
            S_PADDR: r_next.pins.io_out = r_next.poll_sh[7:0];
            S_RCMD: r_next.pins.io_out = CMD_READ1;
            default: r_next.pins.io_out = 8'h0;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r_reg <= '0;
            r_reg.st <= S_IDLE;
            r_reg.pins <= '{ce_n: 1'b1, we_n: 1'b1, re_n: 1'b1,
                default: 1'b0};
        end else begin
            r_reg <= r_next;
        end
    end

    // bad block table, one bit per block of each lun
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < BBT_N; i++) begin
                bbt_reg[i] <= 1'b0;
            end
        end else if (bbt_we) begin
            bbt_reg[{r_reg.lun, r_reg.blk}] <= 1'b1;
        end
    end

    assign hreadyout = r_reg.ahb.hreadyout;
    assign hresp = r_reg.ahb.hresp;
    assign hrdata = r_reg.ahb.hrdata;
    assign pins = r_reg.pins;
    assign ecc_sector_end = r_reg.ecc_end;

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_no_plain_status;
        r_reg.pins.cle |-> r_reg.pins.io_out != CMD_STAT_PLAIN;
    endproperty
    a_no_plain_status: assert property (p_no_plain_status)
        else $error("plain status command driven");
    property p_init_gate;
        start_ok && req_op != OP_RESET |-> r_reg.init_done;
    endproperty
    a_init_gate: assert property (p_init_gate)
        else $error("op started before init done");
    property p_init_rb;
        $rose(r_reg.init_done) |-> $past(rb_n);
    endproperty
    a_init_rb: assert property (p_init_rb)
        else $error("init done while rb_n low");
    property p_bad_skip;
        start_ok && (req_op == OP_PROG || req_op == OP_ERASE) |-> !bad_sel;
    endproperty
    a_bad_skip: assert property (p_bad_skip)
        else $error("program or erase on bad block");
    property p_prog_drain;
        start_ok && req_op == OP_PROG |-> !r_reg.rvalid;
    endproperty
    a_prog_drain: assert property (p_prog_drain)
        else $error("program while read data pending");
    property p_lun_ready;
        start_ok && req_op inside {OP_READ, OP_PROG, OP_ERASE}
            |-> !r_reg.lun_busy[row[18]];
    endproperty
    a_lun_ready: assert property (p_lun_ready)
        else $error("op issued to busy lun");
    property p_status_after;
        r_reg.st == S_CMD2 && !r_reg.nowait ##1 r_reg.st == S_WAIT
            |-> ##[1:20] r_reg.st inside {S_PCMD, S_RBWAIT};
    endproperty
    a_status_after: assert property (p_status_after)
        else $error("no status poll after operation");
    property p_poll_addr;
        r_reg.st == S_PCMD ##1 r_reg.st == S_PADDR
            |-> r_reg.pins.ale && r_reg.pins.io_out == r_reg.poll_sh[7:0];
    endproperty
    a_poll_addr: assert property (p_poll_addr)
        else $error("enhanced status without lun address");
    c_reset: cover property (r_reg.st == S_RBWAIT ##1 r_reg.init_done);
    c_prog: cover property (r_reg.st == S_DIN ##[1:50] r_reg.st == S_PRD);
    c_bad: cover property ($rose(r_reg.bad_found));
endmodule : nmlib_host

// ---- nmlib_nand_model.sv ----
// nmlib_nand_model: two-lun nand target as seen at the host pins
// assumes pins change on clk edges; no cache series, ops never fail
module nmlib_nand_model
    import nmlib_pkg::*;
#(
    parameter int BUSY_CYC = 30,
    parameter logic [11:0] BAD_BLK = 12'h005
) (
    // clock
    input wire logic clk,
    // host pins
    input wire nmlib_pins_type pins,
    output logic [7:0] io_in,
    output logic rb_n,
    // plain status command seen
    output logic plain_seen
);
    logic we_q = 1'b1;
    logic re_q = 1'b1;
    logic [7:0] cmd = 8'h00;
    logic [7:0] cache = 8'h00;
    logic [7:0] rd = 8'h00;
    logic [7:0] cnt = 8'h00;
    logic [2:0] na = 3'h0;
    logic [7:0] a [5] = '{default: 8'h00};
    int bz [2] = '{0, 0};
    logic lun;
    logic [11:0] blk;
    logic [7:0] st;
    assign lun = a[4][2];
    assign blk = {a[4][1:0], a[3], a[2][7:6]};
    assign st = {1'b1, bz[lun] == 0, bz[lun] == 0, 5'h00};
    assign rb_n = bz[0] == 0 && bz[1] == 0;
    // released bus shows the inverse of the last byte
    assign io_in = pins.re_n ? ~rd : rd;
    initial plain_seen = 1'b0;
    always @(posedge clk) begin
        we_q <= pins.we_n;
        re_q <= pins.re_n;
        for (int i = 0; i < 2; i++) begin
            if (bz[i] > 0) bz[i] <= bz[i] - 1;
        end
        if (!pins.ce_n && pins.we_n && !we_q) begin
            if (pins.cle) begin
                cmd <= pins.io_out;
                na <= 3'h0;
                cnt <= 8'h00;
                if (pins.io_out == CMD_STAT_PLAIN) plain_seen <= 1'b1;
                if (pins.io_out == CMD_PROG1) cache <= 8'h00;
                if (pins.io_out inside {CMD_READ2, CMD_PROG2, CMD_ERASE2})
                    bz[lun] <= BUSY_CYC;
                if (pins.io_out == CMD_RESET) bz <= '{BUSY_CYC, BUSY_CYC};
            end else if (pins.ale) begin
                // row-only commands land in the row slots
                a[na + ((cmd == CMD_ERASE1 || cmd == CMD_STAT_ENH) ? 3'h2
                    : 3'h0)] <= pins.io_out;
                na <= na + 3'h1;
            end else if (cmd == CMD_PROG1) cache <= pins.io_out;
        end
        if (!pins.re_n && re_q) begin
            cnt <= cnt + 8'h01;
            if (cmd == CMD_STAT_ENH) rd <= st;
            else if ({a[1][4:0], a[0]} == SPARE_COL)
                rd <= blk == BAD_BLK ? BB_MARK : 8'hff;
            else rd <= cache + cnt;
        end
    end
endmodule : nmlib_nand_model

// ---- nmlib_host_tb.sv ----
// nmlib_host_tb: register-level bench for the nand host sequencer
// assumes the pin model answers on the same clock
module nmlib_host_tb
    import nmlib_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic take = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, q;
    logic hreadyout, hresp, rb_n, plain_seen;
    logic [7:0] io_in, wb;
    nmlib_pins_type pins;
    logic [63:0] notes [$];
    int mismatches = 0;
    int checks = 0;
    int len;
    always #10 clk = ~clk;
    nmlib_host nmlib_host_i (.clk(clk), .nrst(nrst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .pins(pins), .io_in(io_in),
        .rb_n(rb_n), .ecc_sector_end());
    nmlib_nand_model nmlib_nand_model_i (.clk(clk), .pins(pins),
        .io_in(io_in), .rb_n(rb_n), .plain_seen(plain_seen));
    task give_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    task automatic wrdy();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            mismatches++;
            $display("wrong value at %0t: bus wait ran out", $time);
            give_verdict();
        end
    endtask : wrdy
    task automatic ahb(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic c);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        wrdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        take <= c;
        wrdy();
        q = hrdata;
        take <= 1'b0;
    endtask : ahb
    task automatic chk(input logic [7:0] a, input logic [31:0] e, m);
        notes.push_back({e, m});
        ahb(1'b0, a, 32'h0, 1'b1);
    endtask : chk
    // poll status until bit b reads v
    task automatic wt(input int b, input logic v);
        int n;
        n = 0;
        repeat (4) @(posedge clk);
        do begin
            ahb(1'b0, REG_STAT, 32'h0, 1'b0);
            n++;
        end while (q[b] !== v && n < 3000);
        if (n >= 3000) begin
            mismatches++;
            $display("wrong value at %0t: status wait ran out", $time);
            give_verdict();
        end
    endtask : wt
    task automatic op(input logic [3:0] o, input logic l,
        input logic [11:0] b);
        ahb(1'b1, REG_ADDR, {l, b, 19'h0}, 1'b0);
        ahb(1'b1, REG_CTRL, {28'h0, o}, 1'b0);
    endtask : op
    always @(posedge clk) begin
        if (take && hreadyout === 1'b1 && notes.size() > 0) begin
            checks++;
            if ((hrdata & notes[0][31:0]) !== notes[0][63:32])
                $display("wrong value at %0t: register %h", $time, haddr);
            if ((hrdata & notes[0][31:0]) !== notes[0][63:32]) mismatches++;
            void'(notes.pop_front());
        end
    end
    initial begin
        void'($urandom(32'h2215fb05));
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        op({1'b0, OP_READ}, 1'b0, 12'h0);
        wt(0, 1'b0);
        chk(REG_STAT, 32'h4, 32'h6);
        op({1'b0, OP_RESET}, 1'b0, 12'h0);
        wt(0, 1'b0);
        chk(REG_STAT, 32'h2, 32'h6);
        $display("test done: init order");
        op({1'b0, OP_BBCHK}, 1'b0, 12'h005);
        wt(0, 1'b0);
        chk(REG_STAT, 32'h10000, 32'h10004);
        op({1'b0, OP_PROG}, 1'b0, 12'h005);
        wt(0, 1'b0);
        chk(REG_STAT, 32'h4, 32'h4);
        op({1'b0, OP_BBCHK}, 1'b0, 12'h000);
        wt(0, 1'b0);
        chk(REG_STAT, 32'h0, 32'h10004);
        op({1'b0, OP_ERASE}, 1'b1, 12'h001);
        wt(0, 1'b0);
        chk(REG_STAT, 32'h6000, 32'h610c);
        $display("test done: bad blocks and erase");
        wb = 8'($urandom);
        len = $urandom_range(4, 1);
        ahb(1'b1, REG_LEN, 32'h1, 1'b0);
        op({1'b1, OP_PROG}, 1'b0, 12'h002);
        ahb(1'b1, REG_WDATA, {24'h0, wb}, 1'b0);
        wt(0, 1'b0);
        chk(REG_STAT, 32'h40, 32'hc4);
        ahb(1'b1, REG_LEN, 32'(len), 1'b0);
        op({1'b0, OP_READ}, 1'b1, 12'h003);
        for (int i = 0; i < len; i++) begin
            wt(4, 1'b1);
            chk(REG_RDATA, 32'(wb + 8'(i)), 32'hff);
        end
        wt(0, 1'b0);
        op({1'b0, OP_READ}, 1'b0, 12'h002);
        wt(0, 1'b0);
        chk(REG_STAT, 32'h4, 32'h4);
        op({1'b0, OP_POLL}, 1'b0, 12'h002);
        wt(0, 1'b0);
        chk(REG_STAT, 32'h0, 32'hcc);
        checks++;
        if (plain_seen !== 1'b0) $display("wrong value at %0t: plain", $time);
        if (plain_seen !== 1'b0) mismatches++;
        chk(8'h20, 32'h0, 32'hffffffff);
        $display("test done: interleave and unmapped");
        give_verdict();
    end
endmodule : nmlib_host_tb
